// ---- rtl/power_reset_pkg.sv ----
// Constants, field layouts and state codes of the power and reset controller
// How it works
// - Off state wakes only on listed sources, resetting
// - Off entry powers core down, aborts tasks
// - Debug active: off emulated, resources stay powered
// - Power-on reset leaves the device on
// - Reset cause register accumulates sources until cleared
// - Idle sub-mode only when on and idle
// - Fixed latency task keeps basic resources on
// - Economy task lets power management choose supply
// - Entering on state defaults to economy idle
// - Off: RAM retained per retention, never accessible
// - On: powered RAM accessible, else retention decides
// - RAM power registers survive the off state
// - Power-on holds reset until supply ready
// - Reset pin, routed by two selects, resets
// - Debug active: off wake spares debug port
// - Core request bit or control port resets softly, except in off
// - Watchdog timeout (except in off) and undervoltage cause reset
// - Lockup and soft reset hit CPU, peripherals, GPIO
// - Off wake spares GPIO, retained, cause, serial port
// - Watchdog and pin spare serial port, cause
// - Lockup reset suppressed under debug and in off
package power_reset_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_FIXED_LATENCY_TASK = 12'h078;
    localparam logic [11:0] OFS_ECONOMY_IDLE_TASK = 12'h07c;
    localparam logic [11:0] OFS_PIN_SELECT0 = 12'h200;
    localparam logic [11:0] OFS_PIN_SELECT1 = 12'h204;
    localparam logic [11:0] OFS_RESET_CAUSE = 12'h400;
    localparam logic [11:0] OFS_OFF_REQUEST = 12'h500;
    localparam logic [11:0] OFS_STATUS = 12'h600;
    localparam logic [11:0] OFS_RAM_FIRST = 12'h900;
    localparam logic [11:0] OFS_RAM_LAST = 12'h988;
    localparam logic [1:0] RAM_SUB_POWER = 2'h0;
    localparam logic [1:0] RAM_SUB_SET = 2'h1;
    localparam logic [1:0] RAM_SUB_CLR = 2'h2;
    localparam int RAM_SECTIONS = 9;
    localparam int RAM_POWER_BIT = 0;
    localparam int RAM_RETAIN_BIT = 16;
    localparam logic RAM_POWER_RESET = 1'b1;
    localparam logic RAM_RETAIN_RESET = 1'b0;
    localparam logic [31:0] PIN_SELECT_RESET = 32'hffffffff;
    localparam int PIN_DISCONNECT_BIT = 31;
    localparam int TASK_TRIGGER_BIT = 0;
    localparam int OFF_ENTER_BIT = 0;
    // Reset cause bit positions
    localparam int CAUSE_PIN = 0;
    localparam int CAUSE_WATCHDOG = 1;
    localparam int CAUSE_SOFT = 2;
    localparam int CAUSE_LOCKUP = 3;
    localparam int CAUSE_GPIO_WAKE = 16;
    localparam int CAUSE_COMP_WAKE = 17;
    localparam int CAUSE_NFC_WAKE = 19;
    localparam int CAUSE_VBUS_WAKE = 20;
    // Status bit positions
    localparam int STAT_OFF = 0;
    localparam int STAT_EMULATED = 1;
    localparam int STAT_FIXED_LATENCY = 2;
    localparam int STAT_IDLE = 3;
    // Reset targets
    localparam int T_CPU = 0;
    localparam int T_PERIPH = 1;
    localparam int T_GPIO = 2;
    localparam int T_DEBUG = 3;
    localparam int T_SERIAL_PORT = 4;
    localparam int T_RAM = 5;
    localparam int T_WATCHDOG = 6;
    localparam int T_RETAINED = 7;
    localparam int T_CAUSE = 8;
    localparam int N_TGT = 9;
    localparam logic [8:0] MASK_SOFT = 9'h007;
    localparam logic [8:0] MASK_WAKE = 9'h06b;
    localparam logic [8:0] MASK_PIN_WDT = 9'h0ef;
    localparam logic [8:0] MASK_FULL = 9'h1ff;
    localparam logic [3:0] RESET_PULSE_CYCLES = 4'h4;
    // Synchronised input indices
    localparam int IN_GPIO = 0;
    localparam int IN_COMP = 1;
    localparam int IN_NFC = 2;
    localparam int IN_VBUS = 3;
    localparam int IN_PIN = 4;
    localparam int IN_DEBUG = 5;
    localparam int IN_CORE_REQ = 6;
    localparam int IN_CTRL_PORT = 7;
    localparam int IN_WDT = 8;
    localparam int IN_UNDERVOLT = 9;
    localparam int IN_LOCKUP = 10;
    localparam int IN_CPU_IDLE = 11;
    localparam int IN_PERIPH_IDLE = 12;
    localparam int IN_SUPPLY_OK = 13;
    localparam int IN_REG_READY = 14;
    localparam int N_IN = 15;
    typedef enum logic [2:0] {
        ST_ON = 3'b001,
        ST_OFF = 3'b010,
        ST_EMU_OFF = 3'b100
    } power_mode_t;
endpackage

// ---- rtl/system_power_reset_control.sv ----
// Power-state, RAM power and reset distribution controller with APB registers
`timescale 1ns/1ps
module system_power_reset_control
    import power_reset_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic gpio_detect,
    input wire logic comparator_wake_signal,
    input wire logic nfc_sense,
    input wire logic vbus_detect,
    input wire logic reset_pin_n,
    input wire logic debug_active,
    input wire logic core_reset_request_bit,
    input wire logic control_access_port_reset,
    input wire logic watchdog_timeout,
    input wire logic undervoltage_reset,
    input wire logic cpu_lockup,
    input wire logic cpu_idle,
    input wire logic periph_idle,
    input wire logic supply_ok,
    input wire logic regulator_ready,
    output logic [N_TGT-1:0] reset_target,
    output logic core_power,
    output logic abort_tasks,
    output logic idle_submode,
    output logic basic_resources_hold,
    output logic economy_power_mgmt,
    output logic [RAM_SECTIONS-1:0] ram_accessible,
    output logic [RAM_SECTIONS-1:0] ram_retained
);
    typedef struct packed {
        logic [N_IN-1:0] sync1;
        logic [N_IN-1:0] sync2;
        power_mode_t mode;
        logic fixed_latency;
        logic [RAM_SECTIONS-1:0] ram_pwr;
        logic [RAM_SECTIONS-1:0] ram_ret;
        logic [31:0] pin_sel0;
        logic [31:0] pin_sel1;
        logic [31:0] cause;
        logic [N_TGT-1:0] tmask;
        logic [3:0] tcnt;
        logic abort;
        logic core_on;
        logic idle_on;
        logic hold_basic;
        logic economy;
        logic [RAM_SECTIONS-1:0] ram_acc;
        logic [RAM_SECTIONS-1:0] ram_keep;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;
    logic [N_IN-1:0] raw_in;
    logic [N_IN-1:0] in;
    logic in_off;
    logic wake_now;
    logic por_hold;
    logic pin_now;
    logic soft_now;
    logic lock_now;
    logic wdt_now;
    logic [N_TGT-1:0] req;
    logic apb_setup;
    logic apb_write;
    logic ram_hit;
    logic [3:0] ram_idx;
    logic [1:0] ram_sub;
    logic addr_hit;
    logic [31:0] read_value;

    assign raw_in = {regulator_ready, supply_ok, periph_idle, cpu_idle, cpu_lockup,
        undervoltage_reset, watchdog_timeout, control_access_port_reset,
        core_reset_request_bit, debug_active, ~reset_pin_n, vbus_detect, nfc_sense,
        comparator_wake_signal, gpio_detect};
    assign in = s.sync2;

    assign prdata = s.rdata;
    assign pready = s.ready;
    assign pslverr = s.slverr;
    assign reset_target = s.tmask;
    assign core_power = s.core_on;
    assign abort_tasks = s.abort;
    assign idle_submode = s.idle_on;
    assign basic_resources_hold = s.hold_basic;
    assign economy_power_mgmt = s.economy;
    assign ram_accessible = s.ram_acc;
    assign ram_retained = s.ram_keep;

    // Source qualification
    always_comb
    begin
        in_off = (s.mode != ST_ON);
        por_hold = !(in[IN_SUPPLY_OK] && in[IN_REG_READY]);
        wake_now = in_off && (in[IN_GPIO] || in[IN_COMP] || in[IN_NFC] || in[IN_VBUS]);
        pin_now = in[IN_PIN] && !s.pin_sel0[PIN_DISCONNECT_BIT]
            && !s.pin_sel1[PIN_DISCONNECT_BIT];
        soft_now = (s.mode != ST_OFF) && (in[IN_CORE_REQ] || in[IN_CTRL_PORT]);
        lock_now = (s.mode == ST_ON) && in[IN_LOCKUP] && !in[IN_DEBUG];
        wdt_now = (s.mode != ST_OFF) && in[IN_WDT];
        req = '0;
        if (lock_now || soft_now)
        begin
            req = req | MASK_SOFT;
        end
        if (wake_now)
        begin
            req = req | MASK_WAKE;
            if (in[IN_DEBUG])
            begin
                req[T_DEBUG] = 1'b0;
            end
        end
        if (wdt_now || pin_now)
        begin
            req = req | MASK_PIN_WDT;
        end
        if (in[IN_UNDERVOLT] || por_hold)
        begin
            req = MASK_FULL;
        end
    end

    // APB decode
    always_comb
    begin
        apb_setup = psel && !penable;
        apb_write = psel && penable && pwrite;
        ram_idx = paddr[7:4];
        ram_sub = paddr[3:2];
        ram_hit = (paddr >= OFS_RAM_FIRST) && (paddr <= OFS_RAM_LAST)
            && (ram_sub <= RAM_SUB_CLR) && (paddr[1:0] == 2'h0);
        addr_hit = ram_hit || paddr == OFS_FIXED_LATENCY_TASK
            || paddr == OFS_ECONOMY_IDLE_TASK || paddr == OFS_PIN_SELECT0
            || paddr == OFS_PIN_SELECT1 || paddr == OFS_RESET_CAUSE
            || paddr == OFS_OFF_REQUEST || paddr == OFS_STATUS;
        read_value = 32'h00000000;
        if (ram_hit)
        begin
            read_value[RAM_POWER_BIT] = s.ram_pwr[ram_idx];
            read_value[RAM_RETAIN_BIT] = s.ram_ret[ram_idx];
        end
        else
        begin
            case (paddr)
                OFS_PIN_SELECT0: read_value = s.pin_sel0;
                OFS_PIN_SELECT1: read_value = s.pin_sel1;
                OFS_RESET_CAUSE: read_value = s.cause;
                OFS_STATUS:
                begin
                    read_value[STAT_OFF] = in_off;
                    read_value[STAT_EMULATED] = (s.mode == ST_EMU_OFF);
                    read_value[STAT_FIXED_LATENCY] = s.fixed_latency;
                    read_value[STAT_IDLE] = s.idle_on;
                end
                default: read_value = 32'h00000000;
            endcase
        end
    end

    always_comb
    begin
        next_s = s;
        next_s.sync1 = raw_in;
        next_s.sync2 = s.sync1;
        next_s.abort = 1'b0;
        next_s.ready = 1'b1;
        next_s.slverr = 1'b0;
        if (apb_setup)
        begin
            next_s.rdata = read_value;
            next_s.slverr = !addr_hit;
        end
        if (apb_write && addr_hit)
        begin
            if (ram_hit)
            begin
                case (ram_sub)
                    RAM_SUB_POWER:
                    begin
                        next_s.ram_pwr[ram_idx] = pwdata[RAM_POWER_BIT];
                        next_s.ram_ret[ram_idx] = pwdata[RAM_RETAIN_BIT];
                    end
                    RAM_SUB_SET:
                    begin
                        next_s.ram_pwr[ram_idx] = s.ram_pwr[ram_idx] | pwdata[RAM_POWER_BIT];
                        next_s.ram_ret[ram_idx] = s.ram_ret[ram_idx] | pwdata[RAM_RETAIN_BIT];
                    end
                    default:
                    begin
                        next_s.ram_pwr[ram_idx] = s.ram_pwr[ram_idx] & ~pwdata[RAM_POWER_BIT];
                        next_s.ram_ret[ram_idx] = s.ram_ret[ram_idx] & ~pwdata[RAM_RETAIN_BIT];
                    end
                endcase
            end
            else
            begin
                case (paddr)
                    OFS_FIXED_LATENCY_TASK:
                    begin
                        if (pwdata[TASK_TRIGGER_BIT])
                        begin
                            next_s.fixed_latency = 1'b1;
                        end
                    end
                    OFS_ECONOMY_IDLE_TASK:
                    begin
                        if (pwdata[TASK_TRIGGER_BIT])
                        begin
                            next_s.fixed_latency = 1'b0;
                        end
                    end
                    OFS_PIN_SELECT0: next_s.pin_sel0 = pwdata;
                    OFS_PIN_SELECT1: next_s.pin_sel1 = pwdata;
                    OFS_RESET_CAUSE: next_s.cause = s.cause & ~pwdata;
                    OFS_OFF_REQUEST:
                    begin
                        if (pwdata[OFF_ENTER_BIT] && s.mode == ST_ON)
                        begin
                            // Debug session keeps core power and RAM access alive; tasks still abort
                            next_s.mode = in[IN_DEBUG] ? ST_EMU_OFF : ST_OFF;
                            next_s.abort = 1'b1;
                        end
                    end
                    default: next_s.rdata = s.rdata;
                endcase
            end
        end
        // Cause bits are set after the software clear so an event is never lost
        if (pin_now)
        begin
            next_s.cause[CAUSE_PIN] = 1'b1;
        end
        if (wdt_now)
        begin
            next_s.cause[CAUSE_WATCHDOG] = 1'b1;
        end
        if (soft_now)
        begin
            next_s.cause[CAUSE_SOFT] = 1'b1;
        end
        if (lock_now)
        begin
            next_s.cause[CAUSE_LOCKUP] = 1'b1;
        end
        if (wake_now)
        begin
            next_s.cause[CAUSE_GPIO_WAKE] = next_s.cause[CAUSE_GPIO_WAKE] | in[IN_GPIO];
            next_s.cause[CAUSE_COMP_WAKE] = next_s.cause[CAUSE_COMP_WAKE] | in[IN_COMP];
            next_s.cause[CAUSE_NFC_WAKE] = next_s.cause[CAUSE_NFC_WAKE] | in[IN_NFC];
            next_s.cause[CAUSE_VBUS_WAKE] = next_s.cause[CAUSE_VBUS_WAKE] | in[IN_VBUS];
        end
        // Any reset that reaches the CPU lands in the on state, economy idle
        if (req[T_CPU])
        begin
            next_s.mode = ST_ON;
            next_s.fixed_latency = 1'b0;
        end
        if (req[T_RETAINED])
        begin
            next_s.ram_pwr = {RAM_SECTIONS{RAM_POWER_RESET}};
            next_s.ram_ret = {RAM_SECTIONS{RAM_RETAIN_RESET}};
        end
        if (req[T_CAUSE])
        begin
            next_s.cause = 32'h00000000;
            next_s.pin_sel0 = PIN_SELECT_RESET;
            next_s.pin_sel1 = PIN_SELECT_RESET;
        end
        // Level sources retrigger every cycle while qualified, so the pulse covers the whole qualified assertion; a wake qualifies only until the on state
        if (req != '0)
        begin
            next_s.tmask = ((s.tcnt != 4'h0) ? s.tmask : '0) | req;
            next_s.tcnt = RESET_PULSE_CYCLES;
        end
        else if (s.tcnt != 4'h0)
        begin
            next_s.tcnt = s.tcnt - 4'h1;
            if (s.tcnt == 4'h1)
            begin
                next_s.tmask = '0;
            end
        end
        case (next_s.mode)
            ST_ON, ST_EMU_OFF:
            begin
                next_s.core_on = 1'b1;
                next_s.ram_acc = next_s.ram_pwr;
                next_s.ram_keep = next_s.ram_pwr | next_s.ram_ret;
            end
            ST_OFF:
            begin
                next_s.core_on = 1'b0;
                next_s.ram_acc = '0;
                next_s.ram_keep = next_s.ram_ret;
            end
            default:
            begin
                next_s.core_on = 1'b1;
                next_s.ram_acc = '0;
                next_s.ram_keep = '0;
            end
        endcase
        next_s.idle_on = (next_s.mode == ST_ON) && in[IN_CPU_IDLE] && in[IN_PERIPH_IDLE];
        next_s.hold_basic = next_s.idle_on && next_s.fixed_latency;
        next_s.economy = next_s.idle_on && !next_s.fixed_latency;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '{sync1: '0, sync2: '0, mode: ST_ON, fixed_latency: 1'b0,
                ram_pwr: {RAM_SECTIONS{RAM_POWER_RESET}},
                ram_ret: {RAM_SECTIONS{RAM_RETAIN_RESET}},
                pin_sel0: PIN_SELECT_RESET, pin_sel1: PIN_SELECT_RESET,
                cause: 32'h00000000, tmask: MASK_FULL, tcnt: RESET_PULSE_CYCLES,
                abort: 1'b0, core_on: 1'b1, idle_on: 1'b0, hold_basic: 1'b0,
                economy: 1'b0, ram_acc: '0, ram_keep: '0, rdata: 32'h00000000,
                ready: 1'b1, slverr: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_off_core_down: assert property (s.mode == ST_OFF |-> !core_power)
        else $error("core powered in off state");
    a_off_abort: assert property ($rose(s.mode == ST_OFF) |-> abort_tasks)
        else $error("off entry without task abort");
    a_emu_powered: assert property (s.mode == ST_EMU_OFF |-> core_power && in_off)
        else $error("emulated off dropped core power");
    a_wake_reset: assert property (wake_now |=> reset_target[T_CPU] && s.mode == ST_ON)
        else $error("wake did not reset into on state");
    a_wake_economy: assert property (wake_now |=> !s.fixed_latency && !basic_resources_hold)
        else $error("wake left fixed latency selected");
    a_debug_spared: assert property (wake_now && in[IN_DEBUG] && s.tcnt == 4'h0
        && !pin_now && !wdt_now && !in[IN_UNDERVOLT] && !por_hold |=> !reset_target[T_DEBUG])
        else $error("debug reset on wake during debug session");
    a_lockup_gated: assert property (in[IN_DEBUG] && s.tcnt == 4'h0 && !soft_now
        && (req & ~MASK_SOFT) == '0 |=> reset_target == '0)
        else $error("lockup reset while debugging");
    a_soft_targets: assert property (s.tcnt == 4'h0 && req == MASK_SOFT
        |=> reset_target == MASK_SOFT && !$rose(s.cause[CAUSE_PIN]))
        else $error("soft reset touched spared targets");
    a_pulse_len: assert property ($rose(|reset_target) |-> (|reset_target) [*4])
        else $error("reset pulse shorter than four cycles");
    a_off_ram: assert property (s.mode == ST_OFF
        |-> ram_accessible == '0 && ram_retained == s.ram_ret)
        else $error("ram accessible in off state");
    a_pin_cause: assert property (pin_now && !in[IN_UNDERVOLT] && !por_hold
        |=> s.cause[CAUSE_PIN] && reset_target[T_WATCHDOG])
        else $error("pin reset not recorded");
    a_idle_on_only: assert property (idle_submode |-> s.mode == ST_ON)
        else $error("idle sub-mode outside on state");
    a_task_fixed: assert property (apb_write && paddr == OFS_FIXED_LATENCY_TASK
        && pwdata[TASK_TRIGGER_BIT] && req == '0 |=> s.fixed_latency)
        else $error("fixed latency task ignored");
endmodule

// ---- dv/source_model.sv ----
// Far-side model: wake sources, reset requesters and the reset pin
`timescale 1ns/1ps
module source_model
(
    input wire logic [9:0] req,
    output logic gpio_detect,
    output logic comparator_wake_signal,
    output logic nfc_sense,
    output logic vbus_detect,
    output logic reset_pin_n,
    output logic core_reset_request_bit,
    output logic control_access_port_reset,
    output logic watchdog_timeout,
    output logic undervoltage_reset,
    output logic cpu_lockup
);
    // Requests are levels that the bench changes just after a clock edge
    assign gpio_detect = req[0];
    assign comparator_wake_signal = req[1];
    assign nfc_sense = req[2];
    assign vbus_detect = req[3];
    // Driven as ~req[4], so the pin rests high whenever req[4] is clear
    assign reset_pin_n = ~req[4];
    assign core_reset_request_bit = req[5];
    assign control_access_port_reset = req[6];
    assign watchdog_timeout = req[7];
    assign undervoltage_reset = req[8];
    assign cpu_lockup = req[9];
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the power and reset controller
`timescale 1ns/1ps
module tb;
    import power_reset_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    logic pready, pslverr, er;
    logic [9:0] req = 10'h000;
    logic debug_active = 0, cpu_idle = 1, periph_idle = 1, supply_ok = 1, regulator_ready = 1;
    logic gpio_detect, comparator_wake_signal, nfc_sense, vbus_detect, reset_pin_n;
    logic core_reset_request_bit, control_access_port_reset, watchdog_timeout;
    logic undervoltage_reset, cpu_lockup, core_power, abort_tasks, idle_submode;
    logic basic_resources_hold, economy_power_mgmt;
    logic [N_TGT-1:0] reset_target;
    logic [RAM_SECTIONS-1:0] ram_accessible, ram_retained, pw, ret;
    int errors = 0, n_tests = 0, cycles = 0, aborts = 0, seed = 87;
    int wake_bit[4] = '{CAUSE_GPIO_WAKE, CAUSE_COMP_WAKE, CAUSE_NFC_WAKE, CAUSE_VBUS_WAKE};
    int src_idx[5] = '{4, 5, 6, 7, 9};
    int src_bit[5] = '{CAUSE_PIN, CAUSE_SOFT, CAUSE_SOFT, CAUSE_WATCHDOG, CAUSE_LOCKUP};
    logic [8:0] src_mask[5] = '{MASK_PIN_WDT, MASK_SOFT, MASK_SOFT, MASK_PIN_WDT, MASK_SOFT};

    always #5 pclk = ~pclk;

    system_power_reset_control DUT
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .gpio_detect, .comparator_wake_signal, .nfc_sense, .vbus_detect,
        .reset_pin_n, .debug_active, .core_reset_request_bit, .control_access_port_reset,
        .watchdog_timeout, .undervoltage_reset, .cpu_lockup, .cpu_idle, .periph_idle,
        .supply_ok, .regulator_ready, .reset_target, .core_power, .abort_tasks,
        .idle_submode, .basic_resources_hold, .economy_power_mgmt, .ram_accessible,
        .ram_retained
    );

    source_model far_side
    (
        .req, .gpio_detect, .comparator_wake_signal, .nfc_sense, .vbus_detect,
        .reset_pin_n, .core_reset_request_bit, .control_access_port_reset,
        .watchdog_timeout, .undervoltage_reset, .cpu_lockup
    );

    task automatic results();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (abort_tasks === 1'b1)
            aborts <= aborts + 1;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Ends when pready is seen high; the bench timeout ends a stalled wait
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask

    function automatic logic [31:0] st(input logic off, emu, fix, idle);
        return {28'h0, idle, fix, emu, off};
    endfunction

    // Source held a random few cycles past the point where the targets must be up
    task automatic fire(input int i, input logic [8:0] m);
        @(posedge pclk);
        req[i] <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("reset_target", {23'h0, m}, {23'h0, reset_target});
        repeat (1 + {$random(seed)} % 4) @(posedge pclk);
        req[i] <= 1'b0;
        repeat (12) @(posedge pclk);
        chk("reset_target idle", 32'h0, {23'h0, reset_target});
    endtask

    task automatic settle();
        int t;
        t = 0;
        while (reset_target !== 9'h000 && t < 40)
        begin
            @(posedge pclk);
            t++;
        end
        chk("reset_target clear", 32'h0, {23'h0, reset_target});
    endtask

    // No bus traffic is pending or issued around the off request
    task automatic off();
        wr(OFS_OFF_REQUEST, 32'h1);
        repeat (4) @(posedge pclk);
    endtask

    initial
    begin
        #12;
        chk("reset_target in reset", 32'h1ff, {23'h0, reset_target});
        @(posedge pclk);
        presetn <= 1'b1;
        settle();
        rdc(OFS_STATUS, st(0, 0, 0, 1), "status");
        chk("economy", 32'h1, {31'h0, economy_power_mgmt});
        rdc(OFS_PIN_SELECT0, PIN_SELECT_RESET, "pin select");
        rdc(OFS_RESET_CAUSE, 32'h0, "cause");
        rdc(OFS_RAM_FIRST, 32'h1, "ram reset");
        rdc(12'h004, 32'h0, "unmapped");
        chk("pslverr", 32'h1, {31'h0, er});
        wr(OFS_FIXED_LATENCY_TASK, 32'h1);
        repeat (3) @(posedge pclk);
        rdc(OFS_STATUS, st(0, 0, 1, 1), "status");
        chk("basic hold", 32'h1, {31'h0, basic_resources_hold});
        cpu_idle <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("idle", 32'h0, {31'h0, idle_submode});
        cpu_idle <= 1'b1;
        wr(OFS_ECONOMY_IDLE_TASK, 32'h1);
        repeat (3) @(posedge pclk);
        rdc(OFS_STATUS, st(0, 0, 0, 1), "status");
        wr(OFS_FIXED_LATENCY_TASK, 32'h1);
        for (int n = 0; n < RAM_SECTIONS; n++)
        begin
            v = $random(seed) & 32'h00010001;
            pw[n] = v[0];
            ret[n] = v[16];
            wr(OFS_RAM_FIRST + 12'(16 * n), v);
        end
        repeat (3) @(posedge pclk);
        chk("accessible", {23'h0, pw}, {23'h0, ram_accessible});
        chk("retained", {23'h0, pw | ret}, {23'h0, ram_retained});
        for (int i = 0; i < 4; i++)
        begin
            off();
            chk("core power", 32'h0, {31'h0, core_power});
            chk("abort", i + 1, aborts);
            chk("accessible off", 32'h0, {23'h0, ram_accessible});
            chk("retained off", {23'h0, ret}, {23'h0, ram_retained});
            if (i == 0)
                fire(7, 9'h000);
            fire(i, MASK_WAKE);
            rdc(OFS_RESET_CAUSE, 32'h1 << wake_bit[i], "cause");
            wr(OFS_RESET_CAUSE, 32'hffffffff);
            rdc(OFS_STATUS, st(0, 0, 0, 1), "status");
        end
        for (int n = 0; n < RAM_SECTIONS; n++)
            rdc(OFS_RAM_FIRST + 12'(16 * n), {15'h0, ret[n], 15'h0, pw[n]}, "ram");
        wr(OFS_RAM_FIRST + {8'h0, RAM_SUB_SET, 2'h0}, 32'h00010001);
        rdc(OFS_RAM_FIRST, 32'h00010001, "ram set");
        wr(OFS_RAM_FIRST + {8'h0, RAM_SUB_CLR, 2'h0}, 32'h00000001);
        rdc(OFS_RAM_FIRST, 32'h00010000, "ram clear");
        chk("accessible clear", 32'h0, {31'h0, ram_accessible[0]});
        chk("retained clear", 32'h1, {31'h0, ram_retained[0]});
        fire(4, 9'h000);
        wr(OFS_PIN_SELECT0, 32'h0);
        wr(OFS_PIN_SELECT1, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            fire(src_idx[i], src_mask[i]);
            rdc(OFS_RESET_CAUSE, 32'h1 << src_bit[i], "cause");
            wr(OFS_RESET_CAUSE, 32'hffffffff);
        end
        debug_active <= 1'b1;
        fire(9, 9'h000);
        off();
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status emulated", 32'h3, rd & 32'h3);
        chk("core power emulated", 32'h1, {31'h0, core_power});
        fire(0, MASK_WAKE & ~(9'h001 << T_DEBUG));
        debug_active <= 1'b0;
        fire(8, MASK_FULL);
        rdc(OFS_RESET_CAUSE, 32'h0, "cause");
        rdc(OFS_PIN_SELECT1, PIN_SELECT_RESET, "pin select");
        regulator_ready <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("reset_target supply", 32'h1ff, {23'h0, reset_target});
        regulator_ready <= 1'b1;
        settle();
        results();
    end
endmodule
